// *** rtl/ssrw_pkg.sv ***
// Package: constants and types for the supply supervisor, reset and watchdog block
package ssrw_pkg;

    // ----------------------------------------
    // Clock and time base
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_TICK_PS = 1000000000;
    localparam int MS_TICK_CYCLES = MS_TICK_PS / CLK_PERIOD_PS;
    // Early warning sample period, about 30 kHz
    localparam int SAMPLE_PERIOD_PS = 33000000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_PS / CLK_PERIOD_PS;

    // ----------------------------------------
    // Counts of time base ticks
    // ----------------------------------------
    localparam int CNT_W = 16;
    // Internal base is one tick per ms: 100 ms nominal, above the 50 ms floor
    localparam logic [15:0] INT_STRETCH_TICKS = 16'h0064;
    localparam logic [15:0] INT_WD_LONG_TICKS = 16'h0A8C;
    localparam logic [15:0] INT_WD_SHORT_TICKS = 16'h00AA;
    localparam logic [15:0] EXT_STRETCH_TICKS = 16'h0281;
    localparam logic [15:0] EXT_WD_FIRST_TICKS = 16'h5000;
    localparam logic [15:0] EXT_WD_TICKS = 16'h1400;
    localparam int PB_TICKS = 20;
    localparam logic [1:0] EARLY_SAMPLES = 2'h3;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    localparam int EV_W = 4;
    localparam int EV_SUPPLY = 0;
    localparam int EV_WDOG = 1;
    localparam int EV_BUTTON = 2;
    localparam int EV_EARLY = 3;
    localparam int CTRL_WD_EN = 0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [0:0] CTRL_RESET = 1'h1;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_FAIL = 2'b00,
        ST_STRETCH = 2'b01,
        ST_RUN = 2'b10
    } ssrw_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ssrw_bus_req_s;

    typedef struct packed {
        logic base;
        logic sample;
    } ssrw_tick_s;

endpackage : ssrw_pkg

// *** rtl/ssrw_tick_gen.sv ***
// Time base and sample tick generator for the supply supervisor
`timescale 1ns/1ps
module ssrw_tick_gen #(
    parameter int MS_DIV = ssrw_pkg::MS_TICK_CYCLES,
    parameter int SAMPLE_DIV = ssrw_pkg::SAMPLE_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic internal_sel_in,
    input wire logic osc_in,
    output ssrw_pkg::ssrw_tick_s ticks_out
);
    localparam int MW = $clog2(MS_DIV + 1);
    localparam int SW = $clog2(SAMPLE_DIV + 1);

    logic [MW-1:0] ms_cnt_reg;
    logic [MW-1:0] ms_cnt_next;
    logic [SW-1:0] smp_cnt_reg;
    logic [SW-1:0] smp_cnt_next;
    logic osc_prev_reg;
    logic osc_prev_next;
    logic ms_wrap;
    logic smp_wrap;
    logic osc_rise;

    always_comb begin
        ms_wrap = ms_cnt_reg == MW'(MS_DIV - 1);
        smp_wrap = smp_cnt_reg == SW'(SAMPLE_DIV - 1);
        ms_cnt_next = ms_wrap ? '0 : ms_cnt_reg + MW'(1);
        smp_cnt_next = smp_wrap ? '0 : smp_cnt_reg + SW'(1);
        osc_prev_next = osc_in;
        osc_rise = osc_in & ~osc_prev_reg;
        // Internal divider or external clock edges drive the base tick; the sample tick always comes from the internal divider
        ticks_out.base = ce_in & (internal_sel_in ? ms_wrap : osc_rise);
        ticks_out.sample = ce_in & smp_wrap;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ms_cnt_reg <= '0;
            smp_cnt_reg <= '0;
            osc_prev_reg <= 1'b0;
        end else if (ce_in) begin
            ms_cnt_reg <= ms_cnt_next;
            smp_cnt_reg <= smp_cnt_next;
            osc_prev_reg <= osc_prev_next;
        end
    end

endmodule : ssrw_tick_gen

// *** rtl/ssrw_top.sv ***
// Supply supervisor with reset stretch, pushbutton debounce, watchdog and early warning
//
// Contract
// - Bad supply forces threshold flag and resets
// - Threshold flag releases at once on recovery
// - Resets held at least 50 ms after recovery
// - Bad supply raises power-fail, blocks memory select
// - Protection waits for current memory cycle
// - Debounced pushbutton press asserts resets
// - Watchdog timeout forces both resets active
// - Strobe falling edge restarts watchdog count
// - Watchdog flag shows a timeout happened
// - Source select picks internal or external base
// - Power-fail output is active high
// - Early warning drives active-low interrupt
// - Watchdog counts only with resets inactive
// - Three low samples in a row raise warning
// - Watchdog flag latched until strobe edge
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module ssrw_top #(
    parameter int MS_TICK_CYCLES_P = ssrw_pkg::MS_TICK_CYCLES,
    parameter int SAMPLE_CYCLES_P = ssrw_pkg::SAMPLE_CYCLES,
    parameter int PB_TICKS_P = ssrw_pkg::PB_TICKS
) (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CE_IN,
    input wire logic SUPPLY_OK_IN,
    input wire logic EARLY_BELOW_IN,
    input wire logic BUTTON_RESET_N_IN,
    input wire logic WATCHDOG_KICK_STROBE_N_IN,
    input wire logic TIMING_OSC_INPUT_IN,
    input wire logic TIMING_SOURCE_SELECT_IN,
    input wire logic MEM_SELECT_N_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    output logic IRQ_OUT,
    output logic RESET_THRESHOLD_FLAG_N_OUT,
    output logic RST_OUT,
    output logic RST_N_OUT,
    output logic POWER_FAIL_FLAG_OUT,
    output logic WATCHDOG_EXPIRED_FLAG_N_OUT,
    output logic EARLY_WARN_INT_N_OUT,
    output logic MEM_SELECT_N_OUT
);

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    ssrw_pkg::ssrw_tick_s ticks;
    ssrw_pkg::ssrw_bus_req_s req;

    ssrw_tick_gen #(
        .MS_DIV(MS_TICK_CYCLES_P),
        .SAMPLE_DIV(SAMPLE_CYCLES_P)
    ) u_tick (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .ce_in(CE_IN),
        .internal_sel_in(TIMING_SOURCE_SELECT_IN),
        .osc_in(TIMING_OSC_INPUT_IN),
        .ticks_out(ticks)
    );

    // ----------------------------------------
    // Supervisor state
    // ----------------------------------------
    localparam logic [15:0] PB_LAST = 16'(PB_TICKS_P - 1);

    ssrw_pkg::ssrw_state_e state_reg;
    ssrw_pkg::ssrw_state_e state_next;
    logic [15:0] st_cnt_reg;
    logic [15:0] st_cnt_next;
    logic [15:0] wd_cnt_reg;
    logic [15:0] wd_cnt_next;
    logic [15:0] pb_cnt_reg;
    logic [15:0] pb_cnt_next;
    logic first_reg;
    logic first_next;
    logic kick_prev_reg;
    logic wds_reg;
    logic wds_next;
    logic rst_reg;
    logic rvt_reg;
    logic pf_reg;
    logic protect_reg;
    logic protect_next;
    logic [15:0] st_lim;
    logic [15:0] wd_lim;
    logic stretch_done;
    logic kick;
    logic pb_accept;
    logic wd_en;
    logic wd_timeout;

    always_comb begin
        kick = kick_prev_reg & ~WATCHDOG_KICK_STROBE_N_IN;
        st_lim = TIMING_SOURCE_SELECT_IN ? ssrw_pkg::INT_STRETCH_TICKS
                                         : ssrw_pkg::EXT_STRETCH_TICKS;
        if (!TIMING_SOURCE_SELECT_IN) begin
            wd_lim = first_reg ? ssrw_pkg::EXT_WD_FIRST_TICKS : ssrw_pkg::EXT_WD_TICKS;
        end else begin
            wd_lim = (first_reg || TIMING_OSC_INPUT_IN) ? ssrw_pkg::INT_WD_LONG_TICKS
                                                        : ssrw_pkg::INT_WD_SHORT_TICKS;
        end
        pb_cnt_next = pb_cnt_reg;
        pb_accept = 1'b0;
        if (BUTTON_RESET_N_IN) begin
            pb_cnt_next = '0;
        end else if (ticks.base) begin
            // Held button re-accepts every tick, so reset stays asserted
            if (pb_cnt_reg == PB_LAST) begin
                pb_accept = 1'b1;
            end else begin
                pb_cnt_next = pb_cnt_reg + 16'h0001;
            end
        end
        stretch_done = ticks.base && (st_cnt_reg == st_lim - 16'h0001);
        wd_timeout = (state_reg == ssrw_pkg::ST_RUN) && SUPPLY_OK_IN && !pb_accept
                     && wd_en && !kick && ticks.base
                     && (wd_cnt_reg == wd_lim - 16'h0001);
        state_next = state_reg;
        st_cnt_next = st_cnt_reg;
        wd_cnt_next = '0;
        first_next = first_reg;
        case (state_reg)
            ssrw_pkg::ST_FAIL: begin
                st_cnt_next = '0;
                if (SUPPLY_OK_IN) begin
                    state_next = ssrw_pkg::ST_STRETCH;
                end
            end
            ssrw_pkg::ST_STRETCH: begin
                if (!SUPPLY_OK_IN) begin
                    state_next = ssrw_pkg::ST_FAIL;
                end else if (pb_accept) begin
                    st_cnt_next = '0;
                end else if (stretch_done) begin
                    state_next = ssrw_pkg::ST_RUN;
                    first_next = 1'b1;
                end else if (ticks.base) begin
                    st_cnt_next = st_cnt_reg + 16'h0001;
                end
            end
            ssrw_pkg::ST_RUN: begin
                st_cnt_next = '0;
                wd_cnt_next = wd_cnt_reg;
                if (!SUPPLY_OK_IN) begin
                    state_next = ssrw_pkg::ST_FAIL;
                end else if (pb_accept || wd_timeout) begin
                    state_next = ssrw_pkg::ST_STRETCH;
                    wd_cnt_next = '0;
                end else if (kick) begin
                    wd_cnt_next = '0;
                    first_next = 1'b0;
                end else if (ticks.base && wd_en) begin
                    wd_cnt_next = wd_cnt_reg + 16'h0001;
                end
            end
            default: begin
                state_next = ssrw_pkg::ST_FAIL;
            end
        endcase
        // Flag set wins over the clearing strobe edge
        if (wd_timeout || !SUPPLY_OK_IN) begin
            wds_next = 1'b1;
        end else if (kick) begin
            wds_next = 1'b0;
        end else begin
            wds_next = wds_reg;
        end
        // Protection only arms between memory cycles, releases at once
        protect_next = !SUPPLY_OK_IN && (protect_reg || MEM_SELECT_N_IN);
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= ssrw_pkg::ST_FAIL;
            st_cnt_reg <= '0;
            wd_cnt_reg <= '0;
            pb_cnt_reg <= '0;
            first_reg <= 1'b1;
            kick_prev_reg <= 1'b1;
            wds_reg <= 1'b1;
            rst_reg <= 1'b1;
            rvt_reg <= 1'b1;
            pf_reg <= 1'b1;
            protect_reg <= 1'b1;
        end else if (CE_IN) begin
            state_reg <= state_next;
            st_cnt_reg <= st_cnt_next;
            wd_cnt_reg <= wd_cnt_next;
            pb_cnt_reg <= pb_cnt_next;
            first_reg <= first_next;
            kick_prev_reg <= WATCHDOG_KICK_STROBE_N_IN;
            wds_reg <= wds_next;
            rst_reg <= state_next != ssrw_pkg::ST_RUN;
            rvt_reg <= !SUPPLY_OK_IN;
            pf_reg <= !SUPPLY_OK_IN;
            protect_reg <= protect_next;
        end
    end

    // ----------------------------------------
    // Early warning filter
    // ----------------------------------------
    logic [1:0] early_cnt_reg;
    logic [1:0] early_cnt_next;
    logic nmi_reg;
    logic nmi_next;

    always_comb begin
        early_cnt_next = early_cnt_reg;
        if (ticks.sample) begin
            if (!EARLY_BELOW_IN) begin
                early_cnt_next = 2'h0;
            end else if (early_cnt_reg != ssrw_pkg::EARLY_SAMPLES) begin
                early_cnt_next = early_cnt_reg + 2'h1;
            end
        end
        nmi_next = early_cnt_next == ssrw_pkg::EARLY_SAMPLES;
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            early_cnt_reg <= 2'h0;
            nmi_reg <= 1'b0;
        end else if (CE_IN) begin
            early_cnt_reg <= early_cnt_next;
            nmi_reg <= nmi_next;
        end
    end

    // ----------------------------------------
    // Register file and interrupt
    // ----------------------------------------
    logic [3:0] status_reg;
    logic [3:0] status_next;
    logic [3:0] mask_reg;
    logic [3:0] mask_next;
    logic [0:0] ctrl_reg;
    logic [0:0] ctrl_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [3:0] events;

    always_comb begin
        req = '{addr: REG_ADDR_IN, wdata: REG_WDATA_IN, wr: REG_WR_IN, rd: REG_RD_IN};
        wd_en = ctrl_reg[ssrw_pkg::CTRL_WD_EN];
        events = '0;
        events[ssrw_pkg::EV_SUPPLY] = !SUPPLY_OK_IN && !rvt_reg;
        events[ssrw_pkg::EV_WDOG] = wd_timeout;
        events[ssrw_pkg::EV_BUTTON] = pb_accept;
        events[ssrw_pkg::EV_EARLY] = nmi_next && !nmi_reg;
        status_next = status_reg;
        mask_next = mask_reg;
        ctrl_next = ctrl_reg;
        if (req.wr) begin
            case (req.addr)
                ssrw_pkg::ADDR_STATUS: status_next = status_reg & ~req.wdata[3:0];
                ssrw_pkg::ADDR_MASK: mask_next = req.wdata[3:0];
                ssrw_pkg::ADDR_CTRL: ctrl_next = req.wdata[0:0];
                default: ;
            endcase
        end
        status_next = status_next | events;
        rdata_next = '0;
        if (req.rd) begin
            case (req.addr)
                ssrw_pkg::ADDR_STATUS: rdata_next = {28'h0000000, status_reg};
                ssrw_pkg::ADDR_MASK: rdata_next = {28'h0000000, mask_reg};
                ssrw_pkg::ADDR_CTRL: rdata_next = {31'h00000000, ctrl_reg};
                ssrw_pkg::ADDR_STATE: rdata_next = {23'h000000, first_reg, protect_reg,
                    nmi_reg, pf_reg, rvt_reg, rst_reg, wds_reg, state_reg};
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            status_reg <= '0;
            mask_reg <= ssrw_pkg::MASK_RESET;
            ctrl_reg <= ssrw_pkg::CTRL_RESET;
            rdata_reg <= '0;
        end else if (CE_IN) begin
            status_reg <= status_next;
            mask_reg <= mask_next;
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign REG_RDATA_OUT = rdata_reg;
    assign IRQ_OUT = |(status_reg & mask_reg);
    assign RST_OUT = rst_reg;
    assign RST_N_OUT = ~rst_reg;
    assign RESET_THRESHOLD_FLAG_N_OUT = ~rvt_reg;
    assign POWER_FAIL_FLAG_OUT = pf_reg;
    assign WATCHDOG_EXPIRED_FLAG_N_OUT = ~wds_reg;
    assign EARLY_WARN_INT_N_OUT = ~nmi_reg;
    // Combinational so a running memory cycle is not cut short
    assign MEM_SELECT_N_OUT = MEM_SELECT_N_IN | protect_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    AST_SUPPLY_RESET: assert property (CE_IN && !SUPPLY_OK_IN |=>
        RST_OUT && !RST_N_OUT && !RESET_THRESHOLD_FLAG_N_OUT)
        else $error("Resets not active after supply fault");
    AST_RVT_RELEASE: assert property (CE_IN && SUPPLY_OK_IN |=>
        RESET_THRESHOLD_FLAG_N_OUT)
        else $error("Threshold flag not released with good supply");
    AST_STRETCH_END: assert property ($fell(RST_OUT) |->
        $past(state_reg) == ssrw_pkg::ST_STRETCH && $past(stretch_done))
        else $error("Reset released before stretch count finished");
    AST_PF_PROTECT: assert property (CE_IN && !SUPPLY_OK_IN && MEM_SELECT_N_IN |=>
        POWER_FAIL_FLAG_OUT && MEM_SELECT_N_OUT && $stable(MEM_SELECT_N_OUT)[*1])
        else $error("Power fail or memory block missing");
    AST_MEM_HOLDOFF: assert property ($rose(protect_reg) |->
        $past(MEM_SELECT_N_IN))
        else $error("Protection cut into a memory cycle");
    AST_BUTTON: assert property (CE_IN && pb_accept && SUPPLY_OK_IN |=>
        RST_OUT && state_reg == ssrw_pkg::ST_STRETCH && st_cnt_reg == 16'h0000)
        else $error("Button press did not start reset");
    AST_WD_TIMEOUT: assert property (CE_IN && wd_timeout |=>
        RST_OUT && !WATCHDOG_EXPIRED_FLAG_N_OUT && status_reg[ssrw_pkg::EV_WDOG])
        else $error("Watchdog timeout without reset and flag");
    AST_KICK_RESTART: assert property (CE_IN && kick && SUPPLY_OK_IN && !pb_accept
        && state_reg == ssrw_pkg::ST_RUN |=> wd_cnt_reg == 16'h0000 && !first_reg)
        else $error("Strobe edge did not restart watchdog");
    AST_WD_IDLE: assert property (CE_IN && state_reg != ssrw_pkg::ST_RUN |=>
        wd_cnt_reg == 16'h0000)
        else $error("Watchdog counted while reset active");
    AST_EARLY_WARN: assert property ($fell(EARLY_WARN_INT_N_OUT) |->
        $past(early_cnt_reg) == 2'h2 && $past(ticks.sample) && $past(EARLY_BELOW_IN))
        else $error("Early warning without three low samples");
    AST_WDS_CLEAR: assert property (CE_IN && kick && SUPPLY_OK_IN && !wd_timeout |=>
        WATCHDOG_EXPIRED_FLAG_N_OUT)
        else $error("Strobe edge did not clear watchdog flag");
    AST_BUTTON_COUNT: assert property (pb_accept |->
        !BUTTON_RESET_N_IN && pb_cnt_reg == PB_LAST && $past(!BUTTON_RESET_N_IN))
        else $error("Button accepted before debounce count");

    COV_POWER_UP: cover property ($fell(RST_OUT));
    COV_WD_TIMEOUT: cover property (wd_timeout);
    COV_BUTTON: cover property (pb_accept);
    COV_EARLY: cover property ($fell(EARLY_WARN_INT_N_OUT));

endmodule : ssrw_top

// *** testbench/ssrw_cpu_model.sv ***
// Processor and memory model: watchdog kicks and memory select cycles
`timescale 1ns/1ps
module ssrw_cpu_model (
    input wire logic clk_in,
    input wire logic kick_en_in,
    input wire logic [15:0] kick_per_in,
    input wire logic mem_en_in,
    output logic strobe_n_out,
    output logic mem_sel_n_out
);
    // ----------------------------------------
    // Watchdog kicks
    // ----------------------------------------
    // Period is set by the bench so the model can kick promptly or lag behind
    initial begin
        strobe_n_out = 1'b1;
        forever begin
            repeat (int'(kick_per_in) + 1) @(posedge clk_in);
            if (kick_en_in) begin
                strobe_n_out <= 1'b0;
                repeat (2) @(posedge clk_in);
                strobe_n_out <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Memory cycles
    // ----------------------------------------
    // Six clocks selected, three idle, so a supply drop can land mid cycle
    initial begin
        mem_sel_n_out = 1'b1;
        forever begin
            @(posedge clk_in);
            if (mem_en_in) begin
                mem_sel_n_out <= 1'b0;
                repeat (6) @(posedge clk_in);
                mem_sel_n_out <= 1'b1;
                repeat (2) @(posedge clk_in);
            end
        end
    end
endmodule : ssrw_cpu_model

// *** testbench/tb.sv ***
// Self-checking bench for the supply supervisor with a processor model
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    typedef struct {int sel; logic [31:0] val;} ssrw_note_s;
    logic clk, rst_n, ok, early, btn_n, osc, sel, osc_run, wr, rd, rd_d, kick_en, mem_en;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [15:0] per = 16'h0040;
    logic strobe_n, mem_in, irq, thresh_n, reset, reset_n, pfail, wdog_n, warn_n, mem_out;
    logic [7:0] pins;
    int seed = 33172;
    int n_mismatch = 0;
    int n_checks = 0;
    ssrw_note_s q[$];
    ssrw_note_s cur;
    string nm [0:8] = '{"thresh_n", "reset", "reset_n", "pfail", "wdog_n", "warn_n",
        "mem_out", "irq", "rdata"};
    assign pins = {irq, mem_out, warn_n, wdog_n, pfail, reset_n, reset, thresh_n};

    ssrw_top #(.MS_TICK_CYCLES_P(4), .SAMPLE_CYCLES_P(3), .PB_TICKS_P(2)) dut (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(1'b1), .SUPPLY_OK_IN(ok),
        .EARLY_BELOW_IN(early), .BUTTON_RESET_N_IN(btn_n),
        .WATCHDOG_KICK_STROBE_N_IN(strobe_n), .TIMING_OSC_INPUT_IN(osc),
        .TIMING_SOURCE_SELECT_IN(sel), .MEM_SELECT_N_IN(mem_in), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .IRQ_OUT(irq), .RESET_THRESHOLD_FLAG_N_OUT(thresh_n), .RST_OUT(reset),
        .RST_N_OUT(reset_n), .POWER_FAIL_FLAG_OUT(pfail),
        .WATCHDOG_EXPIRED_FLAG_N_OUT(wdog_n), .EARLY_WARN_INT_N_OUT(warn_n),
        .MEM_SELECT_N_OUT(mem_out));

    ssrw_cpu_model cpu (.clk_in(clk), .kick_en_in(kick_en), .kick_per_in(per),
        .mem_en_in(mem_en), .strobe_n_out(strobe_n), .mem_sel_n_out(mem_in));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // External time base: one rising edge every two clocks
    always @(posedge clk) if (osc_run) osc <= ~osc;
    always @(posedge clk) rd_d <= rd;

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Read data is only valid the cycle after the strobe, so it waits on rd_d
    always @(negedge clk) begin
        if (q.size() > 0 && (q[0].sel < 8 || rd_d)) begin
            cur = q.pop_front();
            check(nm[cur.sel], (cur.sel < 8) ? {31'h0, pins[cur.sel]} : rdata, cur.val);
        end
    end

    task note(input int s, input logic [31:0] v);
        ssrw_note_s e;
        e.sel = s;
        e.val = v;
        q.push_back(e);
    endtask : note

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        note(8, exp);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    task wait_for(input int s, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (pins[s] !== v && n <= hi) begin
            @(negedge clk);
            n++;
        end
        check("span", {31'h0, n >= lo && n <= hi}, 32'h1);
        @(posedge clk);
        note(s, {31'h0, v});
    endtask : wait_for

    task sleep(input int n);
        repeat (n) @(posedge clk);
    endtask : sleep

    task done(input string s);
        $display("test %s done, mismatches %0d", s, n_mismatch);
    endtask : done

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        #(40000 * 5);
        n_mismatch++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {rst_n, ok, early, osc, osc_run, wr, rd, kick_en, mem_en} = 9'h0;
        {btn_n, sel} = 2'h3;
        addr = 8'h00;
        wdata = 32'h0;
        sleep(4);
        note(0, 0); note(1, 1); note(3, 1); note(6, 1);
        @(posedge clk) rst_n <= 1'b1;
        @(posedge clk) ok <= 1'b1;
        @(posedge clk);
        note(0, 1); note(3, 0); note(1, 1);
        wait_for(1, 1'b0, 98 * 4, 102 * 4 + 8);
        note(2, 1);
        wr_reg(8'h00, 32'hF);
        rd_reg(8'h08, 32'h1);
        rd_reg(8'h04, 32'h0);
        wr_reg(8'h10, 32'hFF);
        rd_reg(8'h10, 32'h0);
        done("power-up");
        early <= 1'b1; sleep(4);
        early <= 1'b0; sleep(4);
        note(5, 1);
        early <= 1'b1;
        wait_for(5, 1'b0, 6, 14);
        early <= 1'b0;
        wait_for(5, 1'b1, 1, 8);
        rd_reg(8'h00, 32'h8);
        wr_reg(8'h04, 32'h8);
        note(7, 1);
        wr_reg(8'h00, 32'h8);
        note(7, 0);
        done("early warning");
        per <= 16'h0028 + 16'($random(seed) & 63);
        kick_en <= 1'b1;
        sleep(1500);
        note(1, 0);
        kick_en <= 1'b0;
        wait_for(1, 1'b1, 560, 2700 * 4 + 20);
        note(4, 0);
        wait_for(1, 1'b0, 98 * 4, 102 * 4 + 8);
        // Every reset stretch re-arms the long first period
        wait_for(1, 1'b1, 2698 * 4, 2702 * 4 + 8);
        note(4, 0);
        rd_reg(8'h00, 32'h2);
        wr_reg(8'h00, 32'hF);
        wait_for(1, 1'b0, 98 * 4, 102 * 4 + 8);
        kick_en <= 1'b1;
        wait_for(4, 1'b1, 1, int'(per) + 40);
        done("watchdog");
        btn_n <= 1'b0; sleep(3);
        btn_n <= 1'b1; sleep(12);
        note(1, 0);
        btn_n <= 1'b0;
        wait_for(1, 1'b1, 4, 24);
        btn_n <= 1'b1;
        rd_reg(8'h00, 32'h4);
        wr_reg(8'h00, 32'hF);
        wait_for(1, 1'b0, 98 * 4, 102 * 4 + 16);
        done("button");
        mem_en <= 1'b1;
        while (mem_in !== 1'b1) @(posedge clk);
        while (mem_in !== 1'b0) @(posedge clk);
        ok <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        // Memory select first: the cycle in flight ends a few clocks later
        note(6, 0);
        note(0, 0); note(1, 1); note(2, 0); note(4, 0);
        note(3, 1);
        while (mem_in !== 1'b1) @(posedge clk);
        while (mem_in !== 1'b0) @(posedge clk);
        note(6, 1);
        rd_reg(8'h00, 32'h1);
        done("supply loss");
        mem_en <= 1'b0; sel <= 1'b0; osc_run <= 1'b1;
        sleep(10);
        ok <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        note(0, 1);
        wait_for(1, 1'b0, 639 * 2, 643 * 2 + 8);
        done("external base");
        sleep(4);
        tally_and_finish();
    end
endmodule : tb
